// ===== logic/switch_control_regs.svh
// Register offset, field positions, reset values and timing for the switch control register
`ifndef CTRL_REGS_SVH
`define CTRL_REGS_SVH
`define CTRL_OFF 12'h32c
`define CTRL_B_FUND 0
`define CTRL_B_HOT 1
`define CTRL_B_HOLD 2
`define CTRL_B_UNLOCK 3
`define CTRL_B_PB_UNLOCK 4
`define CTRL_B_LINKDOWN 5
`define CTRL_B_SKIP 6
`define CTRL_B_ORDER 7
`define CTRL_B_PEER 8
`define CTRL_B_CUTTHRU 14
`define CTRL_B_LOCKIGN 15
`define CTRL_B_WAKE_DIR 16
`define CTRL_B_AUX_EN 17
`define CTRL_B_BCAST 18
`define CTRL_RST_FIELD 1'b0
`define CTRL_RST_WAKE_DIR 1'b0
`define CTRL_RST_UNLOCK 1'b0
`define CTRL_RST_RDATA 32'h0000_0000
`define CTRL_CLK_MHZ 100
`define CTRL_RST_TIME_NS 1000
`define CTRL_RST_CYC ((`CTRL_RST_TIME_NS * `CTRL_CLK_MHZ + 999) / 1000)
`endif

// ===== logic/switch_control_pkg.sv
// Types shared by the switch control register and its reset sequencer
package ctrl_pkg;
  // Reset sequencer states, one-hot
  typedef enum logic [4:0] {
    S_FUND = 5'b00001,
    S_HOT = 5'b00010,
    S_EEP = 5'b00100,
    S_HALT = 5'b01000,
    S_RUN = 5'b10000
  } seq_state_t;
endpackage

// ===== logic/sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage, read only by the second; no reset so pins are valid at release
  logic [W-1:0] meta_q;
  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end
endmodule
`default_nettype wire

// ===== logic/reset_seq.sv
// Fundamental / hot reset sequencer with EEPROM step and reset hold
`timescale 1ns/1ps
`default_nettype none
`include "switch_control_regs.svh"
module reset_seq
  import ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic fund_req,
  input wire logic hot_req,
  input wire logic eeprom_mode,
  input wire logic skip_eeprom,
  input wire logic eeprom_done,
  input wire logic hold,
  output seq_state_t state_q,
  output logic eep_start
);
  // Reset pulse length counter
  logic [7:0] cnt_q;
  seq_state_t state_d;
  logic cnt_done;

  assign cnt_done = (cnt_q == 8'(`CTRL_RST_CYC - 1));

  // Next state: fundamental beats hot, hot is ignored while fundamental runs
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_FUND: begin
        if (cnt_done) begin
          state_d = eeprom_mode ? S_EEP : (hold ? S_HALT : S_RUN);
        end
      end
      S_HOT: begin
        if (fund_req) begin
          state_d = S_FUND;
        end else if (cnt_done) begin
          // EEPROM step left out on request, whatever the mode
          state_d = (eeprom_mode && !skip_eeprom) ? S_EEP : (hold ? S_HALT : S_RUN);
        end
      end
      S_EEP: begin
        if (fund_req) begin
          state_d = S_FUND;
        end else if (hot_req) begin
          state_d = S_HOT;
        end else if (eeprom_done) begin
          state_d = hold ? S_HALT : S_RUN;
        end
      end
      S_HALT: begin
        if (fund_req) begin
          state_d = S_FUND;
        end else if (hot_req) begin
          state_d = S_HOT;
        end else if (!hold) begin
          state_d = S_RUN;
        end
      end
      S_RUN: begin
        // Hold has no effect once running; only a new reset revisits it
        if (fund_req) begin
          state_d = S_FUND;
        end else if (hot_req) begin
          state_d = S_HOT;
        end
      end
      default: state_d = S_FUND;
    endcase
  end

  // State register; power-on enters a fundamental reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= S_FUND;
    end else begin
      state_q <= state_d;
    end
  end

  // Counter restarts on every state change
  always_ff @(posedge clk) begin
    if (!rst_b || state_d != state_q) begin
      cnt_q <= 8'h00;
    end else if (!cnt_done) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign eep_start = (state_d == S_EEP) && (state_q != S_EEP);
endmodule
`default_nettype wire

// ===== logic/switch_global_control_register.sv
// Switch global control register with reset sequencing and switch-wide controls
`timescale 1ns/1ps
`default_nettype none
`include "switch_control_regs.svh"
module switch_global_control_register
  import ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input wire logic fund_reset_pin_b,
  input wire logic reset_hold_pin,
  input wire logic eeprom_mode_pin,
  input wire logic aux_power_disable_pin,
  input wire logic wake_pin_in,
  output logic wake_pin_out_q,
  output logic wake_pin_oe_b_q,
  output logic wake_event_q,
  input wire logic wake_req,
  input wire logic link_down,
  input wire logic hot_reset_in,
  input wire logic eeprom_done,
  input wire logic eeprom_error,
  input wire logic eeprom_hold_set,
  output logic fundamental_reset_q,
  output logic hot_reset_q,
  output logic switch_reset_q,
  output logic eeprom_init_start_q,
  output logic protected_write_unlock_q,
  output logic power_budget_unlock_q,
  output logic linkdown_hot_reset_disable_q,
  output logic hot_reset_eeprom_skip_q,
  output logic relaxed_ordering_disable_q,
  output logic peer_traffic_disable_q,
  output logic cut_through_disable_q,
  output logic lock_semantics_ignore_q,
  output logic broadcast_discard_q,
  output logic wake_pin_direction_q,
  output logic aux_power_enable_q
);
  // Synchronised pins
  logic fund_pin_b_s;
  logic hold_pin_s;
  logic eep_mode_s;
  logic aux_dis_s;
  logic wake_s;
  // Register state not brought out
  logic reset_hold_q;
  logic fund_pulse_q;
  logic hot_pulse_q;
  logic por_pend_q;
  // Decode and sequencer wires
  logic wr_hit;
  logic fund_req;
  logic hot_req;
  logic in_fund;
  logic eep_start;
  seq_state_t seq_state;

  // Pins cross into the core clock through two flops
  sync2 #(
    .W(5)
  ) i_sync2 (
    .clk(clk),
    .d({fund_reset_pin_b, reset_hold_pin, eeprom_mode_pin, aux_power_disable_pin, wake_pin_in}),
    .q({fund_pin_b_s, hold_pin_s, eep_mode_s, aux_dis_s, wake_s})
  );

  // Word access to this register's offset, used for writes and reads
  function automatic logic hit(input logic en, input logic [11:0] a);
    hit = en && (a == `CTRL_OFF);
  endfunction

  assign wr_hit = hit(reg_wr_en, reg_addr);
  assign in_fund = (seq_state == S_FUND);

  // Reset causes; a link-down hot reset can be masked, others cannot
  assign fund_req = fund_pulse_q || !fund_pin_b_s;
  assign hot_req = hot_pulse_q || hot_reset_in || (link_down && !linkdown_hot_reset_disable_q);

  reset_seq i_reset_seq (
    .clk(clk),
    .rst_b(rst_b),
    .fund_req(fund_req),
    .hot_req(hot_req),
    .eeprom_mode(eep_mode_s),
    .skip_eeprom(hot_reset_eeprom_skip_q),
    .eeprom_done(eeprom_done),
    .hold(reset_hold_q),
    .state_q(seq_state),
    .eep_start(eep_start)
  );

  // Trigger bits are write-one pulses and store nothing readable
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fund_pulse_q <= 1'b0;
      hot_pulse_q <= 1'b0;
    end else begin
      fund_pulse_q <= wr_hit && reg_wdata[`CTRL_B_FUND];
      hot_pulse_q <= wr_hit && reg_wdata[`CTRL_B_HOT];
    end
  end

  // Sequencer outputs, registered for clean ports
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fundamental_reset_q <= 1'b1;
      hot_reset_q <= 1'b0;
      switch_reset_q <= 1'b1;
      eeprom_init_start_q <= 1'b0;
    end else begin
      fundamental_reset_q <= in_fund;
      hot_reset_q <= (seq_state == S_HOT);
      switch_reset_q <= (seq_state != S_RUN);
      eeprom_init_start_q <= eep_start;
    end
  end

  // Reset hold: strap during fundamental reset, then software or EEPROM
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reset_hold_q <= `CTRL_RST_FIELD;
    end else if (in_fund) begin
      reset_hold_q <= hold_pin_s;
    end else if (eeprom_error || eeprom_hold_set) begin
      reset_hold_q <= 1'b1;
    end else if (wr_hit) begin
      reset_hold_q <= reg_wdata[`CTRL_B_HOLD];
    end
  end

  // Unlock: set during fundamental and hot reset so the EEPROM may load locked fields
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      protected_write_unlock_q <= `CTRL_RST_UNLOCK;
    end else if (in_fund || seq_state == S_HOT) begin
      protected_write_unlock_q <= 1'b1;
    end else if (wr_hit) begin
      protected_write_unlock_q <= reg_wdata[`CTRL_B_UNLOCK];
    end
  end

  // Locked field: only writable while unlocked
  always_ff @(posedge clk) begin
    if (!rst_b || in_fund) begin
      power_budget_unlock_q <= `CTRL_RST_FIELD;
    end else if (wr_hit && protected_write_unlock_q) begin
      power_budget_unlock_q <= reg_wdata[`CTRL_B_PB_UNLOCK];
    end
  end

  // Sticky controls: cleared by fundamental reset only, hot reset keeps them
  always_ff @(posedge clk) begin
    if (!rst_b || in_fund) begin
      linkdown_hot_reset_disable_q <= `CTRL_RST_FIELD;
      hot_reset_eeprom_skip_q <= `CTRL_RST_FIELD;
      relaxed_ordering_disable_q <= `CTRL_RST_FIELD;
      peer_traffic_disable_q <= `CTRL_RST_FIELD;
      cut_through_disable_q <= `CTRL_RST_FIELD;
      lock_semantics_ignore_q <= `CTRL_RST_FIELD;
      broadcast_discard_q <= `CTRL_RST_FIELD;
    end else if (wr_hit) begin
      linkdown_hot_reset_disable_q <= reg_wdata[`CTRL_B_LINKDOWN];
      hot_reset_eeprom_skip_q <= reg_wdata[`CTRL_B_SKIP];
      relaxed_ordering_disable_q <= reg_wdata[`CTRL_B_ORDER];
      peer_traffic_disable_q <= reg_wdata[`CTRL_B_PEER];
      cut_through_disable_q <= reg_wdata[`CTRL_B_CUTTHRU];
      lock_semantics_ignore_q <= reg_wdata[`CTRL_B_LOCKIGN];
      broadcast_discard_q <= reg_wdata[`CTRL_B_BCAST];
    end
  end

  // Power-on-only fields survive even a fundamental reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_pin_direction_q <= `CTRL_RST_WAKE_DIR;
    end else if (wr_hit) begin
      wake_pin_direction_q <= reg_wdata[`CTRL_B_WAKE_DIR];
    end
  end

  // Aux enable: the strap is caught on the first cycle after power-on release,
  // since a reset branch may only load a constant
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aux_power_enable_q <= `CTRL_RST_FIELD;
      por_pend_q <= 1'b1;
    end else if (por_pend_q) begin
      aux_power_enable_q <= !aux_dis_s;
      por_pend_q <= 1'b0;
    end else if (wr_hit) begin
      aux_power_enable_q <= reg_wdata[`CTRL_B_AUX_EN];
    end
  end

  // Wake pin: drive only when set as output; enable is active low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_pin_out_q <= 1'b0;
      wake_pin_oe_b_q <= 1'b1;
      wake_event_q <= 1'b0;
    end else begin
      wake_pin_out_q <= wake_req;
      wake_pin_oe_b_q <= !wake_pin_direction_q;
      wake_event_q <= !wake_pin_direction_q && wake_s;
    end
  end

  // Read port: one-cycle latency, unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata_q <= `CTRL_RST_RDATA;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd_en;
      reg_rdata_q <= `CTRL_RST_RDATA;
      if (hit(reg_rd_en, reg_addr)) begin
        // Triggers and reserved bits read zero
        reg_rdata_q[`CTRL_B_HOLD] <= reset_hold_q;
        reg_rdata_q[`CTRL_B_UNLOCK] <= protected_write_unlock_q;
        reg_rdata_q[`CTRL_B_PB_UNLOCK] <= power_budget_unlock_q;
        reg_rdata_q[`CTRL_B_LINKDOWN] <= linkdown_hot_reset_disable_q;
        reg_rdata_q[`CTRL_B_SKIP] <= hot_reset_eeprom_skip_q;
        reg_rdata_q[`CTRL_B_ORDER] <= relaxed_ordering_disable_q;
        reg_rdata_q[`CTRL_B_PEER] <= peer_traffic_disable_q;
        reg_rdata_q[`CTRL_B_CUTTHRU] <= cut_through_disable_q;
        reg_rdata_q[`CTRL_B_LOCKIGN] <= lock_semantics_ignore_q;
        reg_rdata_q[`CTRL_B_WAKE_DIR] <= wake_pin_direction_q;
        reg_rdata_q[`CTRL_B_AUX_EN] <= aux_power_enable_q;
        reg_rdata_q[`CTRL_B_BCAST] <= broadcast_discard_q;
      end
    end
  end

  // Checks on the register and sequencer
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_fund_trigger;
    wr_hit && reg_wdata[`CTRL_B_FUND] |-> ##3 fundamental_reset_q;
  endproperty
  a_fund_trigger: assert property (p_fund_trigger) else $error("fund trigger lost");

  property p_trig_read_zero;
    reg_rvalid_q |-> reg_rdata_q[1:0] == 2'b00;
  endproperty
  a_trig_read_zero: assert property (p_trig_read_zero) else $error("trigger read nonzero");

  property p_hot_trigger;
    wr_hit && reg_wdata[`CTRL_B_HOT] && !in_fund |-> ##3 (hot_reset_q || fundamental_reset_q);
  endproperty
  a_hot_trigger: assert property (p_hot_trigger) else $error("hot trigger lost");

  property p_halt_holds;
    // Hold may be cleared in the last halt cycle, so look at the value that chose the state
    seq_state == S_HALT |-> $past(reset_hold_q) ##1 switch_reset_q;
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("halt without hold");

  property p_eep_err_hold;
    eeprom_error && !in_fund |=> reset_hold_q;
  endproperty
  a_eep_err_hold: assert property (p_eep_err_hold) else $error("error did not hold");

  property p_locked_write;
    wr_hit && !protected_write_unlock_q && !in_fund |=> $stable(power_budget_unlock_q);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked field written");

  property p_unlock_in_reset;
    (in_fund || seq_state == S_HOT) |=> protected_write_unlock_q;
  endproperty
  a_unlock_in_reset: assert property (p_unlock_in_reset) else $error("unlock not set");

  property p_linkdown_masked;
    seq_state == S_RUN && link_down && linkdown_hot_reset_disable_q && !hot_reset_in && !hot_pulse_q
      && !fund_req |-> ##2 !hot_reset_q;
  endproperty
  a_linkdown_masked: assert property (p_linkdown_masked) else $error("masked link-down reset");

  property p_skip_eeprom;
    seq_state == S_HOT && hot_reset_eeprom_skip_q |=> seq_state != S_EEP;
  endproperty
  a_skip_eeprom: assert property (p_skip_eeprom) else $error("eeprom step not skipped");

  property p_wake_dir;
    wake_pin_direction_q |=> !wake_pin_oe_b_q;
  endproperty
  a_wake_dir: assert property (p_wake_dir) else $error("wake pin not driven");

  property p_wake_input;
    !wake_pin_direction_q |=> wake_pin_oe_b_q;
  endproperty
  a_wake_input: assert property (p_wake_input) else $error("wake pin driven as input");

  property p_reserved_zero;
    reg_rvalid_q |-> reg_rdata_q[13:9] == 5'h00 && reg_rdata_q[31:19] == 13'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_hot_keeps_sticky;
    seq_state == S_HOT && !wr_hit |=> $stable(cut_through_disable_q);
  endproperty
  a_hot_keeps_sticky: assert property (p_hot_keeps_sticky) else $error("sticky lost");

  c_fund: cover property (in_fund ##1 seq_state == S_RUN);
  c_hot: cover property (seq_state == S_HOT ##1 seq_state == S_EEP);
  c_halt: cover property (seq_state == S_HALT ##1 seq_state == S_RUN);
  c_locked: cover property (wr_hit && !protected_write_unlock_q);
endmodule
`default_nettype wire

// ===== bench/switch_global_control_register_test.sv
// Self-checking testbench for the switch global control register
`timescale 1ns/1ps
`default_nettype none
`include "switch_control_regs.svh"
module switch_global_control_register_test
  import ctrl_pkg::*;
;
  // Compare one value, count it and report a mismatch at once
  `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
  logic clk = 1'b0, rst_b = 1'b0; // Core clock and power-on reset
  logic wr = 1'b0, rd = 1'b0; // Register strobes
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic rvalid, fund_pin_b = 1'b1, hold_pin = 1'b1, eep_pin = 1'b0, aux_dis = 1'b0;
  logic wake_in = 1'b0, wake_out, wake_oe_b, wake_evt, wake_req = 1'b0;
  logic link_down = 1'b0, hot_in = 1'b0, eep_done = 1'b0, eep_err = 1'b0, eep_set = 1'b0;
  logic fund_q, hot_q, sw_rst, eep_start, unl, pbul, dldh, skip, relaxed_ordering_disable, p2p, ctd, lki, bdis, wdir, aux;
  logic eep_seen = 1'b0; // Latches any start pulse of the EEPROM step
  int failures = 0, checks_done = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (eep_start) eep_seen <= 1'b1;
  switch_global_control_register i_switch_global_control_register (.clk(clk), .rst_b(rst_b),
    .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_q(rdata),
    .reg_rvalid_q(rvalid), .fund_reset_pin_b(fund_pin_b), .reset_hold_pin(hold_pin),
    .eeprom_mode_pin(eep_pin), .aux_power_disable_pin(aux_dis), .wake_pin_in(wake_in),
    .wake_pin_out_q(wake_out), .wake_pin_oe_b_q(wake_oe_b), .wake_event_q(wake_evt),
    .wake_req(wake_req), .link_down(link_down), .hot_reset_in(hot_in), .eeprom_done(eep_done),
    .eeprom_error(eep_err), .eeprom_hold_set(eep_set), .fundamental_reset_q(fund_q),
    .hot_reset_q(hot_q), .switch_reset_q(sw_rst), .eeprom_init_start_q(eep_start),
    .protected_write_unlock_q(unl), .power_budget_unlock_q(pbul), .linkdown_hot_reset_disable_q(dldh),
    .hot_reset_eeprom_skip_q(skip), .relaxed_ordering_disable_q(relaxed_ordering_disable), .peer_traffic_disable_q(p2p),
    .cut_through_disable_q(ctd), .lock_semantics_ignore_q(lki), .broadcast_discard_q(bdis),
    .wake_pin_direction_q(wdir), .aux_power_enable_q(aux));
  // Verdict and end of run, shared by the main sequence and every timeout
  task automatic conclude();
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One write cycle: strobe held for a single edge
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One read cycle: data is taken in the cycle that valid stands
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("read valid", 1'b1, rvalid)
    d = rdata;
  endtask
  // Read the register and compare it and the field ports with one expected word
  task automatic check_reg(input logic [31:0] e);
    logic [31:0] d;
    rd_reg(12'h32c, d);
    `CHK("register word", e, d)
    `CHK("field ports", {e[18:14], e[8:3]}, {bdis, aux, wdir, lki, ctd, p2p, relaxed_ordering_disable, skip, dldh, pbul, unl})
  endtask
  // Selects one watched output by index
  function automatic logic pick(input int w);
    case (w)
      0: pick = sw_rst;
      1: pick = hot_q;
      2: pick = fund_q;
      default: pick = eep_seen;
    endcase
  endfunction
  // Bounded wait for a watched output to reach a level
  task automatic wait_for(input int w, input logic v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      if (pick(w) === v) return;
    end
    failures++;
    $display("[ERR] wait %0d expected %h seen %h", w, v, pick(w));
    conclude();
  endtask
  // Watched output must keep a level for n cycles
  task automatic hold_for(input int w, input logic v, input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      `CHK("steady level", v, pick(w))
    end
  endtask
  // One-cycle pulse on a same-domain input
  task automatic pulse(input int w);
    @(posedge clk);
    case (w)
      0: link_down <= 1'b1;
      1: hot_in <= 1'b1;
      2: eep_done <= 1'b1;
      default: eep_err <= 1'b1;
    endcase
    @(posedge clk);
    link_down <= 1'b0; hot_in <= 1'b0; eep_done <= 1'b0; eep_err <= 1'b0;
  endtask
  // Hot reset must last the full count, with no fundamental reset seen during it
  task automatic hot_cycle(input int cnt);
    wait_for(1, 1'b1, 6);
    for (int i = 0; i < 200 && hot_q === 1'b1; i++) begin
      `CHK("no fundamental during hot", 1'b0, fund_q)
      @(posedge clk);
      #1;
      cnt++;
    end
    `CHK("hot reset length", `CTRL_RST_CYC, cnt)
  endtask
  // Power-on: strap holds the switch, unlock set, aux enable from pin
  task automatic t_power_on();
    wait_for(2, 1'b0, 120);
    hold_for(0, 1'b1, 8);
    `CHK("aux enable", 1'b1, aux)
    `CHK("wake output disabled", 1'b1, wake_oe_b)
    check_reg(32'h0002_000C);
    hold_pin <= 1'b0;
    wr_reg(12'h32c, 32'h0002_0008);
    wait_for(0, 1'b0, 5);
  endtask
  // All fields written; reserved and trigger bits stay zero; hold has no effect in run
  task automatic t_fields();
    logic [31:0] d;
    wake_req <= 1'b1;
    wr_reg(12'h32c, 32'hFFFF_FFFC);
    hold_for(0, 1'b0, 3);
    check_reg(32'h0007_C1FC);
    `CHK("wake drive enabled", 1'b0, wake_oe_b)
    `CHK("wake drive value", 1'b1, wake_out)
    wr_reg(12'h32c, 32'h0002_0000);
    check_reg(32'h0002_0000);
    wake_in <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `CHK("wake input seen", 1'b1, wake_evt)
    wr_reg(12'h32c, 32'h0002_0010);
    check_reg(32'h0002_0000);
    wr_reg(12'h32c, 32'h0002_0018);
    check_reg(32'h0002_0008);
    wr_reg(12'h32c, 32'h0002_0018);
    check_reg(32'h0002_0018);
    wr_reg(12'h330, 32'hFFFF_FFFC);
    rd_reg(12'h330, d);
    `CHK("unmapped read", 32'h0000_0000, d)
    check_reg(32'h0002_0018);
  endtask
  // Hot resets: sticky fields kept, link-down masking, other causes kept
  task automatic t_hot();
    wr_reg(12'h32c, 32'h0004_C1E2);
    hot_cycle(0);
    wait_for(0, 1'b0, 5);
    check_reg(32'h0004_C1E8);
    pulse(0);
    hold_for(1, 1'b0, 10);
    pulse(1);
    hot_cycle(0);
    wr_reg(12'h32c, 32'h0004_C1C8);
    pulse(0);
    hot_cycle(0);
    wait_for(0, 1'b0, 5);
  endtask
  // EEPROM step skipped or run; an EEPROM error leaves the switch held
  task automatic t_eeprom();
    eep_pin <= 1'b1;
    repeat (4) @(posedge clk);
    eep_seen = 1'b0;
    wr_reg(12'h32c, 32'h0004_C1CA);
    wait_for(1, 1'b1, 6);
    wait_for(0, 1'b0, 110);
    `CHK("eeprom step skipped", 1'b0, eep_seen)
    wr_reg(12'h32c, 32'h0004_C18A);
    wait_for(3, 1'b1, 120);
    pulse(3);
    pulse(2);
    hold_for(0, 1'b1, 10);
    check_reg(32'h0004_C18C);
    wr_reg(12'h32c, 32'h0004_C188);
    wait_for(0, 1'b0, 5);
  endtask
  // Fundamental reset by register: sticky fields cleared, power-on fields kept
  task automatic t_fund();
    eep_pin <= 1'b0;
    repeat (4) @(posedge clk);
    wr_reg(12'h32c, 32'h0005_C1E9);
    wait_for(2, 1'b1, 6);
    `CHK("no hot during fundamental", 1'b0, hot_q)
    wait_for(2, 1'b0, 110);
    wait_for(0, 1'b0, 5);
    check_reg(32'h0001_0008);
  endtask
  // Second power-on in mid-run: aux enable follows the disabled strap, wake direction clears
  task automatic t_power_cycle();
    aux_dis <= 1'b1;
    repeat (4) @(posedge clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    `CHK("wake dir at power-on", 1'b0, wdir)
    @(posedge clk);
    rst_b <= 1'b1;
    wait_for(2, 1'b0, 120);
    wait_for(0, 1'b0, 5);
    `CHK("aux enable from strap", 1'b0, aux)
    `CHK("wake input after power-on", 1'b1, wake_oe_b)
    check_reg(32'h0000_0008);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_power_on();
    t_fields();
    t_hot();
    t_eeprom();
    t_fund();
    t_power_cycle();
    conclude();
  end
  `undef CHK
endmodule
`default_nettype wire
